// file: msk_write_lanes.sv
// msk_write_lanes: write data, parity and byte-mask launch toward external memory
// assumes: shiftClk is the -90 degree write clock, slower than clk, sampled here;
// assumes: memType, widthMode and parPos are static while writes run
//
// Notes on behaviour
// - In x9, x18 and x36 modes one parity bit is sent with every eight data bits.
// - The parity bit may sit on any pin of its group and is launched like data.
// - Data-mask outputs act for writes to every memory type other than QDR II, including the unlisted code 2.
// - With QDR II memory the byte-write-select outputs pick the written bytes.
// - A low mask or byte-select output marks its byte as valid to write.
// - A high mask or byte-select output makes the memory ignore that byte.
// - Each strobe group has exactly one mask output.
// - Masks are launched on the same shifted clock edge as the write data.
// - Wide parity modes reuse the pins of x8, x16 and x32 and add 1, 2 or 4 lanes.
`timescale 1ns/100ps
module msk_write_lanes (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         shiftClk,
  input  wire logic [1:0]                   memType,
  input  wire logic [2:0]                   widthMode,
  input  wire logic [15:0]                  parPos,
  input  wire logic                         wrValid,
  input  wire logic [msk_pkg::DATA_W-1:0]   wrData,
  input  wire logic [msk_pkg::GROUPS-1:0]   wrByteEn,
  output logic                              wrReady,
  output logic      [msk_pkg::PIN_W-1:0]    dqOut,
  output logic      [msk_pkg::PIN_W-1:0]    dqOe,
  output logic      [msk_pkg::GROUPS-1:0]   dmOut,
  output logic      [msk_pkg::GROUPS-1:0]   bwsN
);

  logic                        shiftSync1;
  logic                        shiftSync2;
  logic                        shiftSync3;
  logic                        launch;
  logic                        take;
  logic                        isQdr;
  logic                        parityOn;
  logic [msk_pkg::GROUPS-1:0]  groupOn;

  // shifted write clock crosses into clk, its rising edge is the launch strobe
  // all ones in reset: a clock already high at release is no edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shiftSync1 <= 1'b1;
      shiftSync2 <= 1'b1;
      shiftSync3 <= 1'b1;
    end else begin
      shiftSync1 <= shiftClk;
      shiftSync2 <= shiftSync1;
      shiftSync3 <= shiftSync2;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrReady <= 1'b0;
    end else begin
      wrReady <= shiftSync2 && !shiftSync3;
    end
  end

  assign launch = wrReady;
  assign take   = wrReady && wrValid;

  // mode decode
  always_comb begin
    isQdr    = (memType == msk_pkg::MSK_MEM_QDR2);
    parityOn = 1'b0;
    groupOn  = 4'h0;
    unique case (msk_pkg::msk_width_t'(widthMode))
      msk_pkg::MSK_W8: begin
        groupOn = 4'h1;
      end
      msk_pkg::MSK_W9: begin
        groupOn  = 4'h1;
        parityOn = 1'b1;
      end
      msk_pkg::MSK_W16: begin
        groupOn = 4'h3;
      end
      msk_pkg::MSK_W18: begin
        groupOn  = 4'h3;
        parityOn = 1'b1;
      end
      msk_pkg::MSK_W32: begin
        groupOn = 4'hF;
      end
      msk_pkg::MSK_W36: begin
        groupOn  = 4'hF;
        parityOn = 1'b1;
      end
      default: begin
        groupOn = 4'h0;
      end
    endcase
  end

  // one lane block, hence one mask, per strobe group
  genvar g;
  generate
    for (g = 0; g < msk_pkg::GROUPS; g = g + 1) begin : gLane
      logic [3:0] posRaw;
      logic [3:0] pos;
      assign posRaw = parPos[4*g +: 4];
      assign pos    = (posRaw > msk_pkg::PARPOS_TOP) ? msk_pkg::PARPOS_TOP : posRaw;
      msk_lane uLane (
        .clk      (clk),
        .rst_n    (rst_n),
        .launch   (launch),
        .take     (take && groupOn[g]),
        .parityOn (parityOn),
        .isQdr    (isQdr),
        .parPos   (pos),
        .data     (wrData[8*g +: 8]),
        .byteEn   (wrByteEn[g]),
        .dq       (dqOut[9*g +: 9]),
        .dqOe     (dqOe[9*g +: 9]),
        .dm       (dmOut[g]),
        .bwsN     (bwsN[g])
      );
    end
  endgenerate

  // checks

  AST_PARITY_EVEN: assert property (
    @(posedge clk) disable iff (!rst_n)
    (take && parityOn && groupOn[0])
      |=> ((^dqOut[8:0]) == msk_pkg::PARITY_ODD) && (dqOe[8:0] == 9'h1FF))
    else $error("group 0 parity bit wrong or not driven");

  AST_PARITY_ANY_PIN: assert property (
    @(posedge clk) disable iff (!rst_n)
    (take && parityOn && parPos[3:0] == 4'h0)
      |=> dqOut[0] == ((^$past(wrData[7:0])) ^ msk_pkg::PARITY_ODD)
          && dqOut[8:1] == $past(wrData[7:0]))
    else $error("parity on pin 0 not placed as a data lane");

  AST_DM_QDR_HIGH: assert property (
    @(posedge clk) disable iff (!rst_n)
    (launch && isQdr) |=> dmOut == 4'hF)
    else $error("data mask driven low for QDR memory");

  AST_BWS_BYTE: assert property (
    @(posedge clk) disable iff (!rst_n)
    (take && isQdr && groupOn[0]) |=> bwsN[0] == !$past(wrByteEn[0]) && dmOut[0])
    else $error("byte write select does not follow byte enable");

  AST_DM_LOW_WRITES: assert property (
    @(posedge clk) disable iff (!rst_n)
    (take && !isQdr && wrByteEn[0] && groupOn[0]) |=> !dmOut[0] && bwsN[0])
    else $error("enabled DDR byte not marked valid");

  AST_DM_HIGH_MASKS: assert property (
    @(posedge clk) disable iff (!rst_n)
    (take && !wrByteEn[0]) |=> dmOut[0] && bwsN[0])
    else $error("disabled byte not masked");

  AST_ONE_MASK_PER_GROUP: assert property (
    @(posedge clk) disable iff (!rst_n)
    (take && groupOn == 4'h1) |=> dmOut[3:1] == 3'h7 && dqOe[35:9] == 27'h0)
    else $error("unused strobe group mask or data active");

  AST_LAUNCH_ALIGNED: assert property (
    @(posedge clk) disable iff (!rst_n)
    !launch |=> $stable(dmOut) && $stable(dqOut) && $stable(bwsN))
    else $error("mask or data moved without a shifted clock edge");

  AST_LANE_REUSE: assert property (
    @(posedge clk) disable iff (!rst_n)
    (take && groupOn[0] && parPos[3:0] == 4'h8)
      |=> dqOut[7:0] == $past(wrData[7:0]))
    else $error("data pins differ from narrow-mode positions");

  AST_IDLE_MASKED: assert property (
    @(posedge clk) disable iff (!rst_n)
    (launch && !wrValid) |=> dmOut == 4'hF && bwsN == 4'hF && dqOe == 36'h0)
    else $error("mask not held high outside a write beat");

  AST_READY_PULSE: assert property (
    @(posedge clk) disable iff (!rst_n)
    wrReady |=> !wrReady)
    else $error("launch strobe longer than one cycle");

  AST_RESET_OUTPUTS: assert property (
    @(posedge clk)
    !rst_n |=> !wrReady && dqOut == 36'h0 && dqOe == 36'h0
               && dmOut == 4'hF && bwsN == 4'hF)
    else $error("outputs not idle after reset");

  AST_PARITY_ALL_GROUPS: assert property (
    @(posedge clk) disable iff (!rst_n)
    (take && parityOn && groupOn == 4'hF)
      |=> ((^dqOut[17:9]) == msk_pkg::PARITY_ODD)
          && ((^dqOut[26:18]) == msk_pkg::PARITY_ODD)
          && ((^dqOut[35:27]) == msk_pkg::PARITY_ODD) && (dqOe == 36'hF_FFFF_FFFF))
    else $error("upper group parity bit wrong or not driven");

  AST_UPPER_GROUPS_QUIET: assert property (
    @(posedge clk) disable iff (!rst_n)
    (launch && groupOn == 4'h3)
      |=> dqOe[35:18] == 18'h0 && dmOut[3:2] == 2'h3 && bwsN[3:2] == 2'h3)
    else $error("groups beyond the sixteen-bit mode active");

  AST_BWS_DDR_HIGH: assert property (
    @(posedge clk) disable iff (!rst_n)
    (launch && !isQdr) |=> bwsN == 4'hF)
    else $error("byte write select driven low for SDRAM");

  AST_MASK_WITH_BEAT: assert property (
    @(posedge clk) disable iff (!rst_n)
    (take && groupOn[0])
      |=> dqOe[0] && dmOut[0] == ($past(isQdr) || !$past(wrByteEn[0])))
    else $error("group 0 mask not aligned with its data beat");

  COV_X36_PARITY: cover property (
    @(posedge clk) disable iff (!rst_n) take && parityOn && groupOn == 4'hF);
  COV_QDR_WRITE: cover property (
    @(posedge clk) disable iff (!rst_n) take && isQdr);
  COV_IDLE_LAUNCH: cover property (
    @(posedge clk) disable iff (!rst_n) launch && !wrValid);
  COV_PARITY_PIN0: cover property (
    @(posedge clk) disable iff (!rst_n) take && parityOn && parPos[3:0] == 4'h0);

endmodule

// file: msk_pkg.sv
// msk_pkg: constants and enumerations for the write-mask and parity lane block
// assumes: nothing beyond a SystemVerilog-2012 compiler
package msk_pkg;

  localparam int unsigned GROUPS    = 4;   // strobe groups at the widest mode
  localparam int unsigned BYTE_W    = 8;   // data bits per group
  localparam int unsigned LANE_W    = 9;   // data plus optional parity lane
  localparam int unsigned PARPOS_W  = 4;   // width of a parity position field
  localparam int unsigned DATA_W    = GROUPS * BYTE_W;
  localparam int unsigned PIN_W     = GROUPS * LANE_W;

  localparam logic [3:0]  PARPOS_TOP     = 4'h8;   // highest legal parity position
  localparam logic        PARITY_ODD     = 1'b0;   // parity sense: 0 even, 1 odd
  localparam logic [3:0]  MASK_ALL       = 4'hF;   // every byte masked
  localparam logic [8:0]  OE_DATA_ONLY   = 9'h0FF;
  localparam logic [8:0]  OE_WITH_PARITY = 9'h1FF;
  localparam logic [8:0]  OE_NONE        = 9'h000;

  localparam int unsigned CLK_PERIOD_NS  = 8;      // core clock, 125 MHz

  typedef enum logic [1:0] {
    MSK_MEM_DDR  = 2'h0,
    MSK_MEM_DDR2 = 2'h1,
    MSK_MEM_QDR2 = 2'h3
  } msk_mem_t;

  typedef enum logic [2:0] {
    MSK_W8  = 3'h0,
    MSK_W9  = 3'h1,
    MSK_W16 = 3'h3,
    MSK_W18 = 3'h2,
    MSK_W32 = 3'h6,
    MSK_W36 = 3'h7
  } msk_width_t;

endpackage

// file: msk_lane.sv
// msk_lane: one strobe group, eight data lanes, one spare lane and one mask
// assumes: launch is a one-cycle pulse on clk; take implies launch
`timescale 1ns/100ps
module msk_lane (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       launch,
  input  wire logic       take,
  input  wire logic       parityOn,
  input  wire logic       isQdr,
  input  wire logic [3:0] parPos,
  input  wire logic [7:0] data,
  input  wire logic       byteEn,
  output logic      [8:0] dq,
  output logic      [8:0] dqOe,
  output logic            dm,
  output logic            bwsN
);

  logic       parityBit;
  logic [8:0] dataExt;
  logic [8:0] lowMask;
  logic [8:0] parMask;
  logic [8:0] next_dq;

  // parity lane sits at parPos, data above it shifts up one pin
  always_comb begin
    parityBit = (^data) ^ msk_pkg::PARITY_ODD;
    dataExt   = {1'b0, data};
    parMask   = 9'h001 << parPos;
    lowMask   = parMask - 9'h001;
    if (parityOn) begin
      next_dq = (dataExt & lowMask) | (parityBit ? parMask : 9'h000)
              | ((dataExt << 1) & ~(lowMask | parMask));
    end else begin
      next_dq = dataExt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dq <= 9'h000;
    end else if (take) begin
      dq <= next_dq;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dqOe <= msk_pkg::OE_NONE;
    end else if (take) begin
      dqOe <= parityOn ? msk_pkg::OE_WITH_PARITY : msk_pkg::OE_DATA_ONLY;
    end else if (launch) begin
      dqOe <= msk_pkg::OE_NONE;
    end
  end

  // low writes the byte, high masks it; each output only for its own memory type
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dm   <= 1'b1;
      bwsN <= 1'b1;
    end else if (launch) begin
      dm   <= !(take && !isQdr && byteEn);
      bwsN <= !(take && isQdr && byteEn);
    end
  end

endmodule

// file: msk_mem_model.sv
// msk_mem_model: memory side model, keeps every pin group it is told to write
// assumes: pins settle one clk after launch and stand at least one cycle
`timescale 1ns/100ps
module msk_mem_model (
  input  wire logic        clk,
  input  wire logic        isQdr,
  input  wire logic [35:0] dq,
  input  wire logic [35:0] dqOe,
  input  wire logic [3:0]  dm,
  input  wire logic [3:0]  bwsN,
  output logic      [35:0] stored
);
  logic [3:0]  sel;
  logic [35:0] mem = '0;

  // qdr listens to byte selects, ddr to masks
  assign sel    = isQdr ? bwsN : dm;
  assign stored = mem;

  always @(posedge clk) begin
    for (int g = 0; g < 4; g++) begin
      if (dqOe[9*g] && !sel[g]) mem[9*g +: 9] <= dq[9*g +: 9];
    end
  end
endmodule

// file: tb_memory_write_mask_parity_lanes.sv
// tb_memory_write_mask_parity_lanes: self-checking bench for msk_write_lanes
// assumes: msk_pkg and msk_mem_model compiled first
`timescale 1ns/100ps
module tb_memory_write_mask_parity_lanes;
  logic        clk = 0, rst_n = 0, shiftClk = 0, wrValid = 0, wrReady;
  logic [1:0]  memType = 0;
  logic [2:0]  widthMode = 0;
  logic [15:0] parPos = 16'h8888;
  logic [31:0] wrData = 0;
  logic [3:0]  wrByteEn = 0, dmOut, bwsN;
  logic [35:0] dqOut, dqOe, stored;
  int          n_fail = 0, num_checks = 0;

  msk_write_lanes msk_write_lanes_i (.clk(clk), .rst_n(rst_n), .shiftClk(shiftClk),
    .memType(memType), .widthMode(widthMode), .parPos(parPos), .wrValid(wrValid),
    .wrData(wrData), .wrByteEn(wrByteEn), .wrReady(wrReady), .dqOut(dqOut),
    .dqOe(dqOe), .dmOut(dmOut), .bwsN(bwsN));
  msk_mem_model msk_mem_model_i (.clk(clk), .isQdr(memType == 2'h3), .dq(dqOut),
    .dqOe(dqOe), .dm(dmOut), .bwsN(bwsN), .stored(stored));

  initial forever #4 clk = ~clk;
  initial forever #40 shiftClk = ~shiftClk;

  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  function automatic logic [8:0] lane(input logic [7:0] b, input logic [3:0] p,
                                      input logic par);
    logic [3:0] q;
    logic [8:0] r;
    int         k;
    q = (p > 4'h8) ? 4'h8 : p;
    r = 9'h000;
    k = 0;
    for (int i = 0; i < 9; i++) begin
      if (par && i == q) r[i] = ^b;
      else if (k < 8) begin
        r[i] = b[k];
        k++;
      end
    end
    return r;
  endfunction

  task automatic waitReady();
    int t;
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (wrReady !== 1'b1 && t < 40);
    if (t >= 40) chk(36'h0, 36'h1, "no ready pulse");
  endtask

  task automatic beat(input logic [1:0] mt, input logic [2:0] wm, input logic [15:0] pp,
                      input logic [31:0] d, input logic [3:0] en, input int ng,
                      input logic par);
    logic [35:0] eq, eo, prev, es;
    logic [3:0]  em;
    eq = '0;
    eo = '0;
    em = 4'hF;
    @(posedge clk);
    memType <= mt;
    widthMode <= wm;
    parPos <= pp;
    wrData <= d;
    wrByteEn <= en;
    wrValid <= 1'b1;
    for (int g = 0; g < ng; g++) begin
      eq[9*g +: 9] = lane(d[8*g +: 8], pp[4*g +: 4], par);
      eo[9*g +: 9] = par ? msk_pkg::OE_WITH_PARITY : msk_pkg::OE_DATA_ONLY;
      em[g] = ~en[g];
    end
    waitReady();
    prev = stored;
    es = prev;
    @(posedge clk);
    wrValid <= 1'b0;
    @(negedge clk);
    chk(dqOut & eo, eq, "lane data");
    chk(dqOe, eo, "lane enables");
    chk({32'h0, (mt == 2'h3) ? dmOut : bwsN}, 36'hF, "unused mask kind");
    chk({32'h0, (mt == 2'h3) ? bwsN : dmOut}, {32'h0, em}, "mask");
    @(negedge clk);
    for (int g = 0; g < ng; g++) if (en[g]) es[9*g +: 9] = eq[9*g +: 9];
    chk(stored & eo, es & eo, "memory contents");
  endtask

  task automatic s_reset();
    chk(dqOe, 36'h0, "reset enables");
    chk(dqOut, 36'h0, "reset data");
    chk({35'h0, wrReady}, 36'h0, "reset ready");
    chk({32'h0, dmOut & bwsN}, 36'hF, "reset masks");
  endtask

  task automatic s_wide();
    beat(2'h0, 3'h7, 16'hF830, 32'hA5C3_5A81, 4'hA, 4, 1'b1);
    beat(2'h1, 3'h7, 16'h1452, 32'h0FF0_3C96, 4'h5, 4, 1'b1);
    beat(2'h1, 3'h6, 16'h8888, 32'h1234_5678, 4'hF, 4, 1'b0);
  endtask

  task automatic s_narrow();
    beat(2'h3, 3'h3, 16'h8888, 32'hDEAD_BEEF, 4'h6, 2, 1'b0);
    beat(2'h3, 3'h2, 16'h0072, 32'h0000_C35A, 4'h1, 2, 1'b1);
    beat(2'h0, 3'h0, 16'h8888, 32'h0000_0077, 4'h1, 1, 1'b0);
    beat(2'h1, 3'h1, 16'h0004, 32'h0000_00E1, 4'h0, 1, 1'b1);
    beat(2'h2, 3'h0, 16'h8883, 32'h0000_0033, 4'h1, 1, 1'b0);
    beat(2'h0, 3'h4, 16'h8888, 32'hFFFF_FFFF, 4'hF, 0, 1'b0);
  endtask

  task automatic s_idle();
    waitReady();
    @(negedge clk);
    chk(dqOe, 36'h0, "idle enables");
    chk({32'h0, dmOut & bwsN}, 36'hF, "idle masks");
  endtask

  task automatic s_midreset();
    beat(2'h0, 3'h0, 16'h8888, 32'h0000_003C, 4'h1, 1, 1'b0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    s_reset();
    @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #20000;
    n_fail++;
    finish_test();
  end

  initial begin
    repeat (19) @(posedge clk);
    @(negedge clk);
    s_reset();
    @(posedge clk);
    rst_n <= 1'b1;
    s_wide();
    s_narrow();
    s_midreset();
    s_idle();
    finish_test();
  end
endmodule
